// File: hw/ext_mem_width_adapter.sv
// External memory width adapter: access sequencing and registered pins
`timescale 1ns/1ps
`include "ext_mem_defs.svh"

module ext_mem_width_adapter (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_srst,
    input  wire ext_mem_pkg::space_cfg_t i_cfg_first,
    input  wire ext_mem_pkg::space_cfg_t i_cfg_second,
    input  wire logic                    i_req,
    input  wire logic                    i_space,
    input  wire logic                    i_write,
    input  wire logic [23:0]             i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic [31:0]             i_mem_rdata,
    output logic                         o_busy,
    output logic                         o_done,
    output logic [31:0]                  o_rdata,
    output logic [23:0]                  o_mem_addr,
    output logic [31:0]                  o_mem_wdata,
    output logic [31:0]                  o_mem_wdata_oe,
    output logic                         o_mem_rw_n,
    output logic [3:0]                   o_first_strobe_n,
    output logic [3:0]                   o_second_strobe_n
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER,
        ST_DONE
    } state_t;

    state_t                  state;
    ext_mem_pkg::space_cfg_t cfg;
    ext_mem_pkg::pin_map_t   map;
    logic                    space;
    logic                    write;
    logic [23:0]             addr;
    logic [31:0]             wdata;
    logic                    half;
    logic                    split;
    logic [31:0]             next_rdata;

    // Configuration chosen per strobe space
    assign cfg = i_space ? i_cfg_second : i_cfg_first;

    ext_mem_lane_map u_map (
        .i_cfg   (space ? i_cfg_second : i_cfg_first),
        .i_addr  (addr),
        .i_wdata (wdata),
        .i_half  (half),
        .o_map   (map)
    );

    // Capture of the request
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            space <= 1'b0;
            write <= 1'b0;
            addr  <= 24'h000000;
            wdata <= 32'h00000000;
            split <= 1'b0;
        end else if (state == ST_IDLE && i_req) begin
            space <= i_space;
            write <= i_write;
            addr  <= i_addr;
            wdata <= i_wdata;
            split <= cfg.width == ext_mem_pkg::MEM_W16 &&
                     cfg.size == ext_mem_pkg::SIZE_32;
        end
    end

    // Transfer sequencing; split access spends one extra cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= ST_IDLE;
            half  <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    half <= 1'b0;
                    if (i_req) begin
                        state <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (split && !half) begin
                        half <= 1'b1;
                    end else begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    half  <= 1'b0;
                end
            endcase
        end
    end

    // Read data assembly from the active lanes
    always_comb begin
        next_rdata = o_rdata;
        if (state == ST_XFER) begin
            if (map.dmask == 32'hFFFFFFFF) begin
                next_rdata = i_mem_rdata;
            end else if (split) begin
                if (half) begin
                    next_rdata = {i_mem_rdata[15:0], o_rdata[15:0]};
                end else begin
                    next_rdata = {16'h0000, i_mem_rdata[15:0]};
                end
            end else if (map.dmask == 32'h0000FF00) begin
                next_rdata = {24'h000000, i_mem_rdata[15:8]};
            end else if (map.dmask == 32'h000000FF) begin
                next_rdata = {24'h000000, i_mem_rdata[7:0]};
            end else begin
                next_rdata = {16'h0000, i_mem_rdata[15:0]};
            end
        end
    end

    // Registered pin drive; strobes idle high between accesses
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_mem_addr        <= 24'h000000;
            o_mem_wdata       <= 32'h00000000;
            o_mem_wdata_oe    <= 32'h00000000;
            o_mem_rw_n        <= 1'b1;
            o_first_strobe_n  <= `EXT_STRB_IDLE;
            o_second_strobe_n <= `EXT_STRB_IDLE;
        end else begin
            o_first_strobe_n  <= `EXT_STRB_IDLE;
            o_second_strobe_n <= `EXT_STRB_IDLE;
            o_mem_wdata_oe    <= 32'h00000000;
            o_mem_rw_n        <= 1'b1;
            if (state == ST_XFER) begin
                o_mem_addr  <= map.addr;
                o_mem_wdata <= map.wdata;
                o_mem_rw_n  <= !write;
                if (write) begin
                    o_mem_wdata_oe <= map.dmask;
                end
                if (space) begin
                    o_second_strobe_n <= map.strb_n;
                end else begin
                    o_first_strobe_n <= map.strb_n;
                end
            end
        end
    end

    // Handshake and read data
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_busy  <= 1'b0;
            o_done  <= 1'b0;
            o_rdata <= 32'h00000000;
        end else begin
            o_busy  <= (state == ST_IDLE) ? i_req : (state == ST_XFER);
            o_done  <= (state == ST_XFER) && !(split && !half);
            o_rdata <= next_rdata;
        end
    end

endmodule // ext_mem_width_adapter

// File: hw/ext_mem_defs.svh
// Constants for the external memory width adapter
// Behaviour
// - 32-bit data on 32-bit memory puts the internal address on the pins unchanged.
// - 32-bit data on 32-bit memory asserts all four byte strobes and moves data bits 31 to 0.
// - On 16-bit memory byte strobe 3 becomes the lowest address bit and strobes 0 and 1 are the lane enables.
// - 8-bit data on 16-bit memory shifts the address right by two and copies bit 23 into bits 23, 22 and 21.
// - 8-bit data on 16-bit memory drives internal address bit 1 onto the strobe-3 address output.
// - 8-bit data on 16-bit memory asserts strobe 0 when address bit 0 is 0 and strobe 1 when it is 1.
// - 8-bit data on 16-bit memory uses data bits 7 to 0 under strobe 0 and bits 15 to 8 under strobe 1.
// - 16-bit data on 16-bit memory shifts the address right by one and copies bit 23 into bits 23 and 22.
// - 16-bit data on 16-bit memory drives the bit dropped by the shift onto the strobe-3 address output.
// - 16-bit data on 16-bit memory asserts strobes 0 and 1 together and moves data bits 15 to 0.
// - 32-bit data on 16-bit memory puts the unshifted address on the pins for both halves.
// - 32-bit data on 16-bit memory splits into two transfers with the strobe-3 address 0 then 1.
// - Both halves of such a split access assert strobes 0 and 1 and move data bits 15 to 0.
// - A split 32-bit access takes one extra wait state over a single transfer.
`ifndef EXT_MEM_DEFS_SVH
`define EXT_MEM_DEFS_SVH

`define EXT_ADDR_W       24
`define EXT_DATA_W       32
`define EXT_LANES        4
`define EXT_SPACES       2
`define EXT_STRB_IDLE    4'hF
`define EXT_STRB_ALL     4'h0
`define EXT_STRB_LANE0   4'hE
`define EXT_STRB_LANE1   4'hD
`define EXT_STRB_LOW2    4'hC
`define EXT_HALVES_SPLIT 2'h2
`define EXT_HALVES_ONE   2'h1

`endif

// File: hw/ext_mem_pkg.sv
// Types for the external memory width adapter
package ext_mem_pkg;

    typedef enum logic {
        MEM_W32,
        MEM_W16
    } mem_width_t;

    typedef enum logic [1:0] {
        SIZE_8,
        SIZE_16,
        SIZE_32
    } data_size_t;

    // Static configuration of one strobe space
    typedef struct packed {
        mem_width_t width;
        data_size_t size;
    } space_cfg_t;

    // Pin image of one external transfer
    typedef struct packed {
        logic [23:0] addr;
        logic [3:0]  strb_n;
        logic [31:0] wdata;
        logic [31:0] dmask;
    } pin_map_t;

endpackage

// File: hw/ext_mem_lane_map.sv
// Combinational address, strobe and data lane mapping for one transfer
`timescale 1ns/1ps
`include "ext_mem_defs.svh"

module ext_mem_lane_map (
    input  wire ext_mem_pkg::space_cfg_t i_cfg,
    input  wire logic [23:0]             i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_half,
    output ext_mem_pkg::pin_map_t        o_map
);

    // Mapping per width and size case
    always_comb begin
        o_map.addr   = i_addr;
        o_map.strb_n = `EXT_STRB_ALL;
        o_map.wdata  = i_wdata;
        o_map.dmask  = 32'hFFFFFFFF;
        if (i_cfg.width == ext_mem_pkg::MEM_W16) begin
            unique case (i_cfg.size)
                ext_mem_pkg::SIZE_8: begin
                    o_map.addr = {{2{i_addr[23]}}, i_addr[23:2]};
                    // Strobe 3 low bit from address bit 1
                    o_map.strb_n = {i_addr[1], 1'b1,
                        i_addr[0] ? 2'h1 : 2'h2};
                    o_map.wdata = {16'h0000, i_wdata[7:0], i_wdata[7:0]};
                    o_map.dmask = i_addr[0] ? 32'h0000FF00
                                            : 32'h000000FF;
                end
                ext_mem_pkg::SIZE_16: begin
                    o_map.addr = {i_addr[23], i_addr[23:1]};
                    o_map.strb_n = {i_addr[0], 3'h4};
                    o_map.wdata = {16'h0000, i_wdata[15:0]};
                    o_map.dmask = 32'h0000FFFF;
                end
                default: begin
                    // Unshifted address, half select on strobe 3
                    o_map.addr = i_addr;
                    o_map.strb_n = {i_half, 3'h4};
                    o_map.wdata = {16'h0000,
                        i_half ? i_wdata[31:16] : i_wdata[15:0]};
                    o_map.dmask = 32'h0000FFFF;
                end
            endcase
        end else begin
            o_map.addr   = i_addr;
            o_map.strb_n = `EXT_STRB_ALL;
        end
    end

endmodule // ext_mem_lane_map

// File: tb/ext_mem_checker.sv
// Port assertions for the external memory width adapter
`timescale 1ns/1ps
module ext_mem_checker (
    input wire logic                    i_clk_sys,
    input wire logic                    i_srst,
    input wire ext_mem_pkg::space_cfg_t i_cfg_first,
    input wire logic                    o_busy,
    input wire logic                    o_done,
    input wire logic [23:0]             o_mem_addr,
    input wire logic [31:0]             o_mem_wdata_oe,
    input wire logic [3:0]              o_first_strobe_n,
    input wire logic [3:0]              o_second_strobe_n
);
    // Transfer on the first space and its mode
    wire x1 = o_first_strobe_n[1:0] != 2'b11;
    wire w16 = i_cfg_first.width == ext_mem_pkg::MEM_W16;
    wire sp = w16 && i_cfg_first.size == ext_mem_pkg::SIZE_32;
    wire any = o_first_strobe_n != 4'hF || o_second_strobe_n != 4'hF;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    property p_rst; disable iff (1'b0)
        i_srst |=> !any && !o_busy && !o_done; endproperty
    a_rst: assert property (p_rst) else $error("strobes active in reset");
    property p_excl; !(o_first_strobe_n != 4'hF && o_second_strobe_n != 4'hF);
    endproperty
    a_excl: assert property (p_excl) else $error("both spaces strobed");
    property p_w32; x1 && !w16 |-> o_first_strobe_n == 4'h0; endproperty
    a_w32: assert property (p_w32) else $error("partial wide strobe");
    property p_w16; x1 && w16 |->
        o_first_strobe_n[2] && o_mem_wdata_oe[31:16] == 16'h0; endproperty
    a_w16: assert property (p_w16) else $error("narrow lane misuse");
    property p_split; x1 && sp && !o_first_strobe_n[3] |=>
        x1 && o_first_strobe_n[3] && $stable(o_mem_addr) && o_done;
    endproperty
    a_split: assert property (p_split) else $error("bad second half");
    property p_single; x1 && !sp |-> o_done; endproperty
    a_single: assert property (p_single) else $error("single not done");
    property p_rise; $rose(o_busy) |=> any; endproperty
    a_rise: assert property (p_rise) else $error("no transfer after start");
    property p_pulse; o_done |=> !o_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
endmodule // ext_mem_checker

// File: tb/sram_model.sv
// Far-side memory model driving the data pins on reads
`timescale 1ns/1ps
module sram_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_busy,
    input  wire logic [31:0] i_word,
    output logic [31:0]      o_rdata
);
    logic second = 1'b0;
    // Marks the second transfer cycle of an access
    always @(posedge i_clk_sys) begin
        second <= i_busy;
    end
    // Released bus shows the inverse; second half shows the upper halfword
    always_comb begin
        o_rdata = ~i_word;
        if (i_busy) begin
            o_rdata = second ? {i_word[15:0], i_word[31:16]} : i_word;
        end
    end
endmodule // sram_model

// File: tb/testbench.sv
// Self-checking bench for the external memory width adapter
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module testbench;
    logic        i_clk_sys = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_req = 1'b0;
    logic        i_space = 1'b0;
    logic        i_write = 1'b0;
    logic [23:0] i_addr = 24'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] word = 32'h0;
    logic [31:0] mem_rd, rdata, mwd, moe;
    logic [23:0] maddr;
    logic [3:0]  s0, s1;
    logic        busy, done, rw_n;
    ext_mem_pkg::space_cfg_t cfg0 = '0;
    ext_mem_pkg::space_cfg_t cfg1 = '0;
    int seed = 45531;
    int compares = 0;
    int mismatches = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    ext_mem_width_adapter u_ext_mem_width_adapter (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cfg_first(cfg0),
        .i_cfg_second(cfg1), .i_req(i_req), .i_space(i_space),
        .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_mem_rdata(mem_rd), .o_busy(busy), .o_done(done), .o_rdata(rdata),
        .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_mem_wdata_oe(moe),
        .o_mem_rw_n(rw_n), .o_first_strobe_n(s0), .o_second_strobe_n(s1));
    sram_model u_sram_model (.i_clk_sys(i_clk_sys), .i_busy(busy),
        .i_word(word), .o_rdata(mem_rd));
    // Expected pin image of one transfer
    function automatic ext_mem_pkg::pin_map_t pin(ext_mem_pkg::space_cfg_t c,
        logic [23:0] a, logic [31:0] d, logic h);
        pin = '{a, 4'h0, d, 32'hFFFFFFFF};
        if (c.width == ext_mem_pkg::MEM_W16) begin
            if (c.size == ext_mem_pkg::SIZE_8) begin
                pin.addr = {a[23], a[23], a[23:2]};
                pin.strb_n = {a[1], 1'b1, ~a[0], a[0]};
                pin.dmask = a[0] ? 32'h0000FF00 : 32'h000000FF;
                pin.wdata = {16'h0, d[7:0], d[7:0]} & pin.dmask;
            end else if (c.size == ext_mem_pkg::SIZE_16) begin
                pin = '{{a[23], a[23:1]}, {a[0], 3'h4}, {16'h0, d[15:0]},
                    32'h0000FFFF};
            end else begin
                pin = '{a, {h, 3'h4}, {16'h0, h ? d[31:16] : d[15:0]},
                    32'h0000FFFF};
            end
        end
    endfunction
    // Configuration of one space from a mode number 0 to 5
    function automatic ext_mem_pkg::space_cfg_t mk(int m);
        mk = '{ext_mem_pkg::mem_width_t'(m >= 3),
            ext_mem_pkg::data_size_t'(m % 3)};
    endfunction
    // One access, checked cycle by cycle
    task automatic acc(logic sp, logic wr, logic [23:0] a, logic [31:0] d);
        ext_mem_pkg::space_cfg_t c;
        ext_mem_pkg::pin_map_t e;
        logic split, x;
        logic [31:0] r;
        c = sp ? cfg1 : cfg0;
        split = c.width == ext_mem_pkg::MEM_W16
            && c.size == ext_mem_pkg::SIZE_32;
        @(posedge i_clk_sys);
        #1;
        {i_space, i_write, i_addr, i_wdata, i_req} = {sp, wr, a, d, 1'b1};
        word = $random(seed);
        @(posedge i_clk_sys);
        #1;
        i_req = 1'b0;
        for (int k = 1; k < 4; k++) begin
            e = pin(c, a, d, k == 3);
            x = k == 2 || (k == 3 && split);
            `CHK("strobe", x ? e.strb_n : 4'hF, sp ? s1 : s0)
            `CHK("other", 4'hF, sp ? s0 : s1)
            `CHK("done", k == (split ? 3 : 2), done)
            `CHK("busy", k < 3 || split, busy)
            if (x) begin
                `CHK("addr", e.addr, maddr)
                `CHK("oe", wr ? e.dmask : 32'h0, moe)
                `CHK("wdata", wr ? e.wdata : 32'h0, mwd & moe)
                `CHK("rw", !wr, rw_n)
            end
            if (done && !wr) begin
                r = (word & e.dmask) >> (c.size == ext_mem_pkg::SIZE_8
                    && a[0] ? 8 : 0);
                if (split || c.width == ext_mem_pkg::MEM_W32) r = word;
                `CHK("rdata", r, rdata)
            end
            @(posedge i_clk_sys);
            #1;
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Corner addresses in every mode, then random traffic
    initial begin
        logic [23:0] ca [3];
        ca = '{24'h004001, 24'h800002, 24'hFFFFFF};
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_srst = 1'b0;
        for (int m = 0; m < 12; m++) begin
            cfg0 = mk(m % 6);
            cfg1 = mk(m % 6);
            foreach (ca[j]) acc(m >= 6, j[0], ca[j] - 24'(m), $random(seed));
        end
        $display("corner test done");
        // Reset while an access is under way
        @(posedge i_clk_sys);
        #1;
        {i_space, i_write, i_req} = 3'b011;
        @(posedge i_clk_sys);
        #1;
        {i_req, i_srst} = 2'b01;
        @(posedge i_clk_sys);
        #1;
        i_srst = 1'b0;
        `CHK("reset strobes", 8'hFF, {s0, s1})
        `CHK("reset busy", 2'b00, {busy, done})
        $display("reset test done");
        repeat (200) begin
            cfg0 = mk($unsigned($random(seed)) % 6);
            cfg1 = mk($unsigned($random(seed)) % 6);
            acc(1'($random(seed)), 1'($random(seed)),
                24'($random(seed)), $random(seed));
        end
        $display("random test done");
        end_sim;
    end
    // Watchdog at about four times the expected run
    initial begin
        #100000;
        mismatches++;
        end_sim;
    end
endmodule // testbench
bind ext_mem_width_adapter ext_mem_checker u_ext_mem_checker (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cfg_first(i_cfg_first),
    .o_busy(o_busy), .o_done(o_done), .o_mem_addr(o_mem_addr),
    .o_mem_wdata_oe(o_mem_wdata_oe), .o_first_strobe_n(o_first_strobe_n),
    .o_second_strobe_n(o_second_strobe_n));
